// [rtl/bps_dev.sv]
/*
 device end: decodes two-cycle commands, tracks open banks and runs the
 auto-close precharge with its row-active lockout.
 assumes the controller keeps all command spacing it is responsible for.
*/
// Operation
// - precharge decoded from cs and ca lines
// - all-bank flag or second-cycle bank code
// - controller waits tRPab or tRPpb before access
// - read to precharge at least BL/2, tRAS
// - activate only after tRP from precharge
// - tRTP counting starts BL/2 minus 8
// - read to precharge covers analog minimum
// - write recovery from edge after last strobe
// - write to precharge WL+BL/2+1+tWR
// - close bank before opening another row
// - auto-close flag engages automatic precharge
// - flag low leaves bank open
// - read auto-close after nRTP, plus 8 for BL32
// - write auto-close tWR after burst end
// - reactivate after tRP and tRC
// - auto-close column commands allowed after tRCD; controller does not wait NRCD and allows them right after activate
// - internal precharge waits for tRAS
// - write then read auto-close covers tWR; a later read reloads the counters with the shorter read figure instead
`timescale 1ns/1ps
`default_nettype none
module bps_dev #(
    parameter int BL = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link
    bps_if.dev link,
    // bank state
    output logic [bps_pkg::NUM_BANKS-1:0] bank_open,
    output logic [bps_pkg::NUM_BANKS-1:0] close_pending,
    output logic [bps_pkg::NUM_BANKS-1:0] precharge_start
);
    localparam int N = bps_pkg::NUM_BANKS;
    localparam int W = bps_pkg::CNT_W;
    localparam int RD_AP = bps_pkg::NRTP + ((BL == 32) ? bps_pkg::BL32_EXTRA : 0);
    localparam int WR_AP = bps_pkg::WL + BL / 2 + bps_pkg::WR_EXTRA + bps_pkg::NWR;
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND} bps_dst_e;
    bps_dst_e st_q, st_d;
    logic [bps_pkg::CA_W-1:0] c1_q, c1_d;
    logic [N-1:0] open_q, open_d, pend_q, pend_d, pstart_q, pstart_d;
    logic [W-1:0] ap_q [N], ap_d [N];
    logic [W-1:0] ras_q [N], ras_d [N];
    logic [bps_pkg::BANK_W-1:0] bank;
    logic [4:0] cmd;
    logic flag;
    logic second;
    logic do_pre;
    logic do_act;
    logic do_col;
    logic [N-1:0] pre_sel;
    logic [N-1:0] due;
    logic [W-1:0] arm_cnt;

    // ------------------------------------------------------------
    // command capture: first half latched, second half decoded live
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        c1_d = c1_q;
        case (st_q)
            ST_IDLE: begin
                if (link.cs) begin
                    c1_d = link.ca;
                    st_d = ST_SECOND;
                end
            end
            ST_SECOND: begin
                st_d = ST_IDLE;
            end
            default: begin
                st_d = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            c1_q <= '0;
        end else begin
            st_q <= st_d;
            c1_q <= c1_d;
        end
    end

    // ------------------------------------------------------------
    // second-half decode
    // ------------------------------------------------------------
    always_comb begin
        bank = link.ca[bps_pkg::BANK_LSB +: bps_pkg::BANK_W];
        cmd = c1_q[4:0];
        flag = c1_q[bps_pkg::FLAG_BIT];
        second = (st_q == ST_SECOND);
        do_pre = second && (cmd == bps_pkg::CMD_PRE);
        do_act = second && (cmd == bps_pkg::CMD_ACT);
        do_col = second && (cmd == bps_pkg::CMD_RD || cmd == bps_pkg::CMD_WR ||
            cmd == bps_pkg::CMD_MWR);
        // reads close after nRTP, writes only after recovery
        arm_cnt = (cmd == bps_pkg::CMD_RD) ? W'(RD_AP) : W'(WR_AP);
        pre_sel = '0;
        for (int i = 0; i < N; i++) begin
            if (flag || i == int'(bank)) begin
                pre_sel[i] = do_pre;
            end
        end
    end

    // ------------------------------------------------------------
    // row-active timers, loaded on activate
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < N; i++) begin
            ras_d[i] = (ras_q[i] != '0) ? ras_q[i] - W'(1) : ras_q[i];
            if (do_act && i == int'(bank)) begin
                ras_d[i] = W'(bps_pkg::NRAS);
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            for (int i = 0; i < N; i++) begin
                ras_q[i] <= '0;
            end
        end else begin
            ras_q <= ras_d;
        end
    end

    // ------------------------------------------------------------
    // auto-close: armed by a flagged burst, held off by row-active time
    // ------------------------------------------------------------
    always_comb begin
        due = '0;
        pend_d = pend_q;
        for (int i = 0; i < N; i++) begin
            ap_d[i] = (ap_q[i] != '0) ? ap_q[i] - W'(1) : ap_q[i];
            // lockout holds the close until row-active time is met
            if (pend_q[i] && ap_q[i] == '0 && ras_q[i] == '0) begin
                due[i] = 1'b1;
                pend_d[i] = 1'b0;
            end
            // an explicit close cancels one still waiting
            if (pre_sel[i]) begin
                pend_d[i] = 1'b0;
            end
            // arming wins over a clear in the same cycle
            if (do_col && flag && i == int'(bank)) begin
                pend_d[i] = 1'b1;
                ap_d[i] = arm_cnt;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            pend_q <= '0;
            for (int i = 0; i < N; i++) begin
                ap_q[i] <= '0;
            end
        end else begin
            pend_q <= pend_d;
            ap_q <= ap_d;
        end
    end

    // ------------------------------------------------------------
    // open rows and precharge start pulses
    // ------------------------------------------------------------
    always_comb begin
        open_d = open_q;
        pstart_d = '0;
        for (int i = 0; i < N; i++) begin
            // a burst without the flag leaves its row open
            if (do_col && !flag && i == int'(bank)) begin
                open_d[i] = open_q[i];
            end
            if (due[i]) begin
                open_d[i] = 1'b0;
                pstart_d[i] = 1'b1;
            end
            // explicit close only reports banks that were really open
            if (pre_sel[i]) begin
                open_d[i] = 1'b0;
                pstart_d[i] = open_q[i];
            end
            if (do_act && i == int'(bank)) begin
                open_d[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            open_q <= '0;
            pstart_q <= '0;
        end else begin
            open_q <= open_d;
            pstart_q <= pstart_d;
        end
    end
    assign bank_open = open_q;
    assign close_pending = pend_q;
    assign precharge_start = pstart_q;
endmodule
`default_nettype wire

// [rtl/bps_pkg.sv]
/*
 bank precharge scheduler package: command encodings, field positions,
 bank count and timing figures shared by the controller and device ends.
 assumes one 50 MHz clock common to both ends.
*/
package bps_pkg;
    // ------------------------------------------------------------
    // link geometry
    // ------------------------------------------------------------
    localparam int CA_W = 6;
    localparam int NUM_BANKS = 8;
    localparam int BANK_W = 3;
    localparam int CNT_W = 8;
    // ------------------------------------------------------------
    // first-cycle command codes on ca[4:0]
    // ------------------------------------------------------------
    localparam logic [4:0] CMD_PRE = 5'h10;
    localparam logic [4:0] CMD_ACT = 5'h01;
    localparam logic [4:0] CMD_RD = 5'h02;
    localparam logic [4:0] CMD_WR = 5'h04;
    localparam logic [4:0] CMD_MWR = 5'h06;
    localparam int FLAG_BIT = 5;
    localparam int BANK_LSB = 0;
    // ------------------------------------------------------------
    // timing figures in ns and derived cycle counts
    // ------------------------------------------------------------
    localparam int CLK_PS = 20000;
    localparam int TRAS_NS = 42;
    localparam int TRP_PB_NS = 18;
    localparam int TRP_AB_NS = 21;
    localparam int TWR_NS = 18;
    localparam int TRTP_NS = 8;
    localparam int TRCD_NS = 18;
    localparam int NRAS = (TRAS_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int NRP_PB = (TRP_PB_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int NRP_AB = (TRP_AB_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int NWR = (TWR_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int NRTP = (TRTP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int NRCD = (TRCD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int BL32_EXTRA = 8;
    localparam int WR_EXTRA = 1;
    localparam int WL = 4;
endpackage

// [rtl/bps_if.sv]
/*
 command link between controller and device: chip select plus six
 command/address lines, each command two cycles long.
 assumes both ends share sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
interface bps_if;
    logic cs;
    logic [bps_pkg::CA_W-1:0] ca;
    modport ctrl (output cs, output ca);
    modport dev (input cs, input ca);
endinterface
`default_nettype wire

// [rtl/bps_ctrl.sv]
/*
 controller end: turns user requests into two-cycle commands and keeps
 per-bank counters so precharge and reopen spacing is honoured.
 assumes the user holds a request until req_ready is seen.
*/
`timescale 1ns/1ps
`default_nettype none
module bps_ctrl #(
    parameter int BL = 16
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // user request
    input wire logic req_valid,
    input wire logic [4:0] req_cmd,
    input wire logic [bps_pkg::BANK_W-1:0] req_bank,
    input wire logic req_flag,
    output logic req_ready,
    // link
    bps_if.ctrl link
);
    localparam int N = bps_pkg::NUM_BANKS;
    localparam int W = bps_pkg::CNT_W;
    localparam int RD_PRE = (BL / 2 > bps_pkg::NRTP + ((BL == 32) ? bps_pkg::BL32_EXTRA : 0)) ?
        BL / 2 : bps_pkg::NRTP + ((BL == 32) ? bps_pkg::BL32_EXTRA : 0);
    localparam int WR_PRE = bps_pkg::WL + BL / 2 + bps_pkg::WR_EXTRA + bps_pkg::NWR;
    typedef enum logic [1:0] {ST_IDLE, ST_SECOND} bps_st_e;
    bps_st_e st_q, st_d;
    logic [W-1:0] pre_q [N], pre_d [N];
    logic [W-1:0] act_q [N], act_d [N];
    logic [W-1:0] ras_q [N], ras_d [N];
    logic cs_q, cs_d;
    logic [bps_pkg::CA_W-1:0] ca_q, ca_d, ca2_q, ca2_d;
    logic ok;
    // rows this end believes open; a second activate must wait for a close
    logic [N-1:0] opn_q, opn_d;

    // ------------------------------------------------------------
    // gating against per-bank counters
    // ------------------------------------------------------------
    always_comb begin
        ok = 1'b1;
        if (req_cmd == bps_pkg::CMD_ACT) begin
            ok = (act_q[req_bank] == '0) && !opn_q[req_bank];
        end else if (req_cmd == bps_pkg::CMD_PRE) begin
            if (req_flag) begin
                for (int i = 0; i < N; i++) begin
                    if (pre_q[i] != '0 || ras_q[i] != '0) ok = 1'b0;
                end
            end else begin
                ok = (pre_q[req_bank] == '0) && (ras_q[req_bank] == '0);
            end
        end else begin
            ok = opn_q[req_bank] &&
                ((act_q[req_bank] == '0) || (ras_q[req_bank] != '0));
        end
    end
    assign req_ready = (st_q == ST_IDLE) && ok;

    // ------------------------------------------------------------
    // command issue and counters, in clock cycles rounded up
    // ------------------------------------------------------------
    always_comb begin
        st_d = st_q;
        cs_d = 1'b0;
        ca_d = '0;
        ca2_d = ca2_q;
        opn_d = opn_q;
        for (int i = 0; i < N; i++) begin
            pre_d[i] = (pre_q[i] != '0) ? pre_q[i] - W'(1) : pre_q[i];
            act_d[i] = (act_q[i] != '0) ? act_q[i] - W'(1) : act_q[i];
            ras_d[i] = (ras_q[i] != '0) ? ras_q[i] - W'(1) : ras_q[i];
        end
        case (st_q)
            ST_IDLE: begin
                if (req_valid && req_ready) begin
                    cs_d = 1'b1;
                    ca_d = {req_flag, req_cmd};
                    ca2_d = {3'h0, req_bank};
                    st_d = ST_SECOND;
                    if (req_cmd == bps_pkg::CMD_ACT) begin
                        ras_d[req_bank] = W'(bps_pkg::NRAS);
                        act_d[req_bank] = W'(bps_pkg::NRAS + bps_pkg::NRP_PB);
                        opn_d[req_bank] = 1'b1;
                    end else if (req_cmd == bps_pkg::CMD_PRE) begin
                        for (int i = 0; i < N; i++) begin
                            if (req_flag || i == int'(req_bank)) begin
                                act_d[i] = W'(req_flag ? bps_pkg::NRP_AB : bps_pkg::NRP_PB);
                                opn_d[i] = 1'b0;
                            end
                        end
                    end else if (req_cmd == bps_pkg::CMD_RD) begin
                        pre_d[req_bank] = W'(RD_PRE);
                        if (req_flag) act_d[req_bank] = W'(RD_PRE + bps_pkg::NRP_PB);
                        if (req_flag) opn_d[req_bank] = 1'b0;
                    end else begin
                        pre_d[req_bank] = W'(WR_PRE);
                        if (req_flag) act_d[req_bank] = W'(WR_PRE + bps_pkg::NRP_PB);
                        if (req_flag) opn_d[req_bank] = 1'b0;
                    end
                end
            end
            ST_SECOND: begin
                cs_d = 1'b0;
                ca_d = ca2_q;
                st_d = ST_IDLE;
            end
            default: st_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (reset) begin
            st_q <= ST_IDLE;
            cs_q <= 1'b0;
            ca_q <= '0;
            ca2_q <= '0;
            opn_q <= '0;
            for (int i = 0; i < N; i++) begin
                pre_q[i] <= '0;
                act_q[i] <= '0;
                ras_q[i] <= '0;
            end
        end else begin
            st_q <= st_d;
            cs_q <= cs_d;
            ca_q <= ca_d;
            ca2_q <= ca2_d;
            opn_q <= opn_d;
            pre_q <= pre_d;
            act_q <= act_d;
            ras_q <= ras_d;
        end
    end
    assign link.cs = cs_q;
    assign link.ca = ca_q;
endmodule
`default_nettype wire

// [verif/bps_chk.sv]
/*
 link and bank-state checker for the precharge scheduler.
 assumes the bench top wires it beside the link, one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module bps_chk (
    // clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // link
    input wire logic cs,
    input wire logic [bps_pkg::CA_W-1:0] ca,
    // bank state
    input wire logic [bps_pkg::NUM_BANKS-1:0] bank_open,
    input wire logic [bps_pkg::NUM_BANKS-1:0] close_pending,
    input wire logic [bps_pkg::NUM_BANKS-1:0] precharge_start
);
    // ------------------------------------------------------------
    // first-half capture and auto-close wait counter
    // ------------------------------------------------------------
    logic sec_q, sec_d, flag_q, flag_d;
    logic [4:0] cmd_q, cmd_d;
    logic [7:0] pend_q, pend_d;
    // cycles since each bank's last activate, saturating
    logic [7:0] age_q [bps_pkg::NUM_BANKS], age_d [bps_pkg::NUM_BANKS];
    logic early;
    always_comb begin
        sec_d = cs;
        flag_d = cs ? ca[5] : flag_q;
        cmd_d = cs ? ca[4:0] : cmd_q;
        pend_d = (|close_pending && !(|precharge_start)) ? pend_q + 8'h01 : 8'h00;
        early = 1'b0;
        for (int k = 0; k < bps_pkg::NUM_BANKS; k++) begin
            age_d[k] = (age_q[k] != 8'hff) ? age_q[k] + 8'h01 : age_q[k];
            if (sec_q && cmd_q == bps_pkg::CMD_ACT && ca[2:0] == 3'(k)) age_d[k] = 8'h00;
            if (precharge_start[k] && age_q[k] < 8'(bps_pkg::NRAS)) early = 1'b1;
        end
    end
    always_ff @(posedge sys_clk) begin
        if (reset) begin
            sec_q <= 1'b0;
            flag_q <= 1'b0;
            cmd_q <= 5'h00;
            pend_q <= 8'h00;
            for (int k = 0; k < bps_pkg::NUM_BANKS; k++) begin
                age_q[k] <= 8'hff;
            end
        end else begin
            sec_q <= sec_d;
            flag_q <= flag_d;
            cmd_q <= cmd_d;
            pend_q <= pend_d;
            age_q <= age_d;
        end
    end
    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    sequence pre_all_s;
        cs && ca == {1'b1, bps_pkg::CMD_PRE};
    endsequence
    sequence col_s;
        sec_q && bank_open[ca[2:0]] && (cmd_q == bps_pkg::CMD_RD ||
            cmd_q == bps_pkg::CMD_WR || cmd_q == bps_pkg::CMD_MWR);
    endsequence
    cs_pulse_a: assert property (cs |=> !cs)
        else $error("command marker longer than one cycle");
    bank_half_a: assert property (cs |=> ca[5:3] == 3'h0)
        else $error("second command half not bank only");
    all_close_a: assert property (pre_all_s |-> ##2 bank_open == 8'h00)
        else $error("all-bank close left a bank open");
    one_close_a: assert property (sec_q && cmd_q == bps_pkg::CMD_PRE && !flag_q
        |=> !bank_open[$past(ca[2:0])]) else $error("selected bank still open");
    ap_arm_a: assert property ((col_s and flag_q) |=> close_pending[$past(ca[2:0])])
        else $error("auto-close not armed");
    no_ap_a: assert property ((col_s and !flag_q) |=> bank_open[$past(ca[2:0])]
        && !close_pending[$past(ca[2:0])]) else $error("plain burst closed bank");
    start_open_a: assert property ((precharge_start & ~$past(bank_open)) == 8'h00)
        else $error("precharge began on a closed bank");
    start_pulse_a: assert property (|precharge_start
        |=> (precharge_start & $past(precharge_start)) == 8'h00) else $error("long pulse");
    ap_bound_a: assert property (pend_q < 8'd24)
        else $error("auto-close precharge overdue");
    ras_hold_a: assert property (!early)
        else $error("bank closed before row-active time");
endmodule
`default_nettype wire

// [verif/bps_tb_top.sv]
/*
 bench top: controller and device joined by the link, user side driven.
 assumes a 50 MHz clock and synchronous active-high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bps_tb_top;
    logic sys_clk = 1'b0;
    logic reset = 1'b1;
    logic req_valid = 1'b0;
    logic [4:0] req_cmd = 5'h00;
    logic [2:0] req_bank = 3'h0;
    logic req_flag = 1'b0;
    logic req_ready;
    logic [7:0] bank_open, close_pending, precharge_start;
    int miscompares = 0;
    int checks = 0;
    int cyc = 0;
    int pulses = 0;
    logic [4:0] col_cmds [3] = '{bps_pkg::CMD_RD, bps_pkg::CMD_WR, bps_pkg::CMD_MWR};
    bps_if lnk ();
    bps_ctrl #(.BL(16)) u_bps_ctrl (.sys_clk(sys_clk), .reset(reset),
        .req_valid(req_valid), .req_cmd(req_cmd), .req_bank(req_bank),
        .req_flag(req_flag), .req_ready(req_ready), .link(lnk));
    bps_dev #(.BL(16)) u_bps_dev (.sys_clk(sys_clk), .reset(reset), .link(lnk),
        .bank_open(bank_open), .close_pending(close_pending),
        .precharge_start(precharge_start));
    bps_chk u_chk (.sys_clk(sys_clk), .reset(reset), .cs(lnk.cs), .ca(lnk.ca),
        .bank_open(bank_open), .close_pending(close_pending),
        .precharge_start(precharge_start));
    always #10 sys_clk = ~sys_clk;
    // run is a few hundred cycles; ceiling leaves wide margin
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (!reset) pulses <= pulses + $countones(precharge_start);
        if (cyc == 3000) begin
            miscompares++;
            close_out();
        end
    end
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // request held until ready seen at a falling edge, taken at next rise
    task automatic issue(input logic [4:0] cmd, input logic [2:0] bank, input logic flag);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b1;
        req_cmd = cmd;
        req_bank = bank;
        req_flag = flag;
        @(negedge sys_clk);
        while (req_ready !== 1'b1) @(negedge sys_clk);
        @(posedge sys_clk);
        #1;
        req_valid = 1'b0;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    initial begin
        logic [2:0] b;
        repeat (10) @(posedge sys_clk);
        #1;
        chk(bank_open, 8'h00);
        reset = 1'b0;
        for (int i = 0; i < 8; i++) issue(bps_pkg::CMD_ACT, 3'(i), 1'b0);
        wait_cyc(4);
        chk(bank_open, 8'hff);
        issue(bps_pkg::CMD_PRE, 3'h3, 1'b0);
        wait_cyc(4);
        chk(bank_open, 8'hf7);
        issue(bps_pkg::CMD_PRE, 3'h3, 1'b1);
        wait_cyc(4);
        chk(bank_open, 8'h00);
        issue(bps_pkg::CMD_PRE, 3'h4, 1'b0);
        wait_cyc(4);
        chk(8'(pulses), 8'h08);
        // plain and auto-close burst for every column command
        for (int i = 0; i < 3; i++) begin
            for (int f = 0; f < 2; f++) begin
                b = 3'(i * 2 + f);
                issue(bps_pkg::CMD_ACT, b, 1'b0);
                issue(col_cmds[i], b, f[0]);
                wait_cyc(30);
                chk({7'h00, bank_open[b]}, {7'h00, ~f[0]});
                chk(close_pending, 8'h00);
            end
        end
        chk(8'(pulses), 8'h0b);
        close_out();
    end
endmodule
`default_nettype wire
